//--- mcg_consts.svh
`ifndef MCG_CONSTS_SVH
`define MCG_CONSTS_SVH
// core clock rate and settling time
`define MCG_CORE_HZ        40000000
`define MCG_SETTLE_MS      5
// longest time rounds down to whole cycles
`define MCG_SETTLE_CYC     ((`MCG_CORE_HZ / 1000) * `MCG_SETTLE_MS)
// select codes {hi, lo}
`define MCG_SEL_50         2'h0
`define MCG_SEL_60         2'h1
`define MCG_SEL_66         2'h2
`define MCG_SEL_TEST       2'h3
// phase accumulator width and per-cycle increments; generated clocks run
// ten times slow (f/400MHz * 2^24) so the ratios survive a 40 MHz core
`define MCG_ACC_W          24
`define MCG_INC_50         24'h1fffff
`define MCG_INC_60         24'h266666
`define MCG_INC_66         24'h2a3d70
`define MCG_INC_33         24'h151eb8
`define MCG_INC_REF        24'h5ba2e8
`endif

//--- mcg_pkg.sv
package mcg_pkg;
  typedef enum logic [1:0] {
    MCG_M50  = 2'h0,
    MCG_M60  = 2'h1,
    MCG_M66  = 2'h2,
    MCG_TEST = 2'h3
  } mcg_mode_t;
endpackage

//--- mcg_fan_if.sv
`timescale 1ns/100ps
interface mcg_fan_if;
  logic       enable_n;
  logic       bank_one_input;
  logic       bank_two_input;
  logic [3:0] bank_one_outputs;
  logic [3:0] bank_two_outputs;
  logic [3:0] bank_one_oe;
  logic [3:0] bank_two_oe;
  modport core (output enable_n, bank_one_input, bank_two_input,
                input bank_one_outputs, bank_two_outputs, bank_one_oe,
                bank_two_oe);
  modport fan  (input enable_n, bank_one_input, bank_two_input,
                output bank_one_outputs, bank_two_outputs, bank_one_oe,
                bank_two_oe);
endinterface

//--- mcg_fanout.sv
`timescale 1ns/100ps
module mcg_fanout (
  // fanout connection
  mcg_fan_if.fan fan
);
  // combinational buffer, like the pin buffers themselves
  always_comb begin
    fan.bank_one_outputs = {4{fan.bank_one_input}}; // R6 R8
    fan.bank_two_outputs = {4{fan.bank_two_input}}; // R6 R8
    fan.bank_one_oe      = {4{~fan.enable_n}};      // R7 R8
    fan.bank_two_oe      = {4{~fan.enable_n}};      // R7 R8
  end
endmodule // mcg_fanout

//--- mcg_top.sv
// What this block does
// R1: processor clock is 50, 60 or 66 MHz from the two select pins.
// R2: bus clock runs at 33 MHz in every non-test setting.
// R3: reference copy replicates the crystal input outside test mode.
// R4: both selects high enters test mode, bypassing oscillator and loops.
// R5: in test mode the crystal input clock drives all three outputs.
// R6: two independent banks each copy one input onto four outputs.
// R7: enable high floats all eight fanout outputs.
// R8: enable low drives each bank's outputs to that bank's input.
// R9: after power-up or select change, allow settling before use.
// R10: outside party supplies a steady reference to the crystal input.
// R11: outside party ties unused inputs high or low.
// R12: settling interval lasts no more than 5 ms.
// R13: unlocked flag and settling counter restart on reset or select change.
`timescale 1ns/100ps
`include "mcg_consts.svh"
module mcg_top #(
  parameter int unsigned SETTLE_CYC = `MCG_SETTLE_CYC
) (
  // clock and power-up reset
  input  wire logic              core_clk_i,
  input  wire logic              arst_n_i,
  // control pins
  input  wire logic              freq_select_lo_i,
  input  wire logic              freq_select_hi_i,
  input  wire logic              fanout_enable_n_i,
  // reference or test clock
  input  wire logic              crystal_input_i,
  // generated clocks, lock flag and mode
  output logic                   processor_clock_out_o,
  output logic                   bus_clock_out_o,
  output logic                   reference_copy_out_o,
  output logic                   clocks_locked_o,
  output mcg_pkg::mcg_mode_t     mode_o,
  // fanout banks
  input  wire logic              bank_one_input_i,
  input  wire logic              bank_two_input_i,
  output logic [3:0]             bank_one_outputs_o,
  output logic [3:0]             bank_two_outputs_o,
  output logic [3:0]             bank_one_oe_o,
  output logic [3:0]             bank_two_oe_o
);
  import mcg_pkg::*;

  localparam int AW = `MCG_ACC_W;
  // last count before lock; the two sync flops, the change detect and the
  // lock flop all fall inside the settle limit, so lock never comes late
  localparam int unsigned LOCK_LAST = SETTLE_CYC - 4;

  typedef struct packed {
    logic [1:0]    sel_s1;
    logic [1:0]    sel_s2;
    logic [1:0]    sel_prev;
    logic          xtal_s1;
    logic          xtal_s2;
    logic [AW-1:0] acc_cpu;
    logic [AW-1:0] acc_bus;
    logic [31:0]   settle_cnt;
    logic          locked;
    logic          cpu_q;
    logic          bus_q;
    logic          ref_q;
    mcg_mode_t     mode;
  } mcg_state_t;

  mcg_state_t st;
  mcg_state_t next_st;

  // increment for the processor accumulator per select code
  function automatic logic [AW-1:0] mcg_cpu_inc(input logic [1:0] sel);
    case (sel)
      `MCG_SEL_50: mcg_cpu_inc = `MCG_INC_50;
      `MCG_SEL_60: mcg_cpu_inc = `MCG_INC_60;
      `MCG_SEL_66: mcg_cpu_inc = `MCG_INC_66;
      default:     mcg_cpu_inc = '0;
    endcase
  endfunction

  // pin synchronisers, settling counter and clock synthesis
  always_comb begin
    next_st          = st;
    next_st.sel_s1   = {freq_select_hi_i, freq_select_lo_i};
    next_st.sel_s2   = st.sel_s1;
    next_st.sel_prev = st.sel_s2;
    next_st.xtal_s1  = crystal_input_i;
    next_st.xtal_s2  = st.xtal_s1;
    next_st.mode     = mcg_mode_t'(st.sel_s2);
    // any select change restarts the settle interval
    if (st.sel_s2 != st.sel_prev) begin
      next_st.settle_cnt = '0; // R13
      next_st.locked     = 1'b0; // R9 R13
    end else if (!st.locked) begin
      if (st.settle_cnt >= LOCK_LAST) begin
        next_st.locked = 1'b1; // R12 R13
      end else begin
        next_st.settle_cnt = st.settle_cnt + 32'h1;
      end
    end
    // phase accumulators: msb is the synthesized clock
    next_st.acc_cpu = st.acc_cpu + mcg_cpu_inc(st.sel_s2); // R1
    next_st.acc_bus = st.acc_bus + `MCG_INC_33; // R2
    if (st.sel_s2 == `MCG_SEL_TEST) begin
      // bypass: test clock passes straight through
      next_st.cpu_q = st.xtal_s2; // R4 R5
      next_st.bus_q = st.xtal_s2; // R4 R5
      next_st.ref_q = st.xtal_s2; // R4 R5
    end else begin
      next_st.cpu_q = st.acc_cpu[AW-1]; // R1
      next_st.bus_q = st.acc_bus[AW-1]; // R2
      next_st.ref_q = st.xtal_s2; // R3
    end
  end

  // single state register; reset models power-up
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign processor_clock_out_o = st.cpu_q;
  assign bus_clock_out_o       = st.bus_q;
  assign reference_copy_out_o  = st.ref_q;
  assign clocks_locked_o       = st.locked;
  assign mode_o                = st.mode;

  // fanout banks; the enable is an async pin, kept combinational like silicon
  mcg_fan_if fan_if ();
  assign fan_if.enable_n       = fanout_enable_n_i;
  assign fan_if.bank_one_input = bank_one_input_i;
  assign fan_if.bank_two_input = bank_two_input_i;
  mcg_fanout u_fanout (
    .fan (fan_if.fan)
  );
  assign bank_one_outputs_o = fan_if.bank_one_outputs;
  assign bank_two_outputs_o = fan_if.bank_two_outputs;
  assign bank_one_oe_o      = fan_if.bank_one_oe;
  assign bank_two_oe_o      = fan_if.bank_two_oe;

  // checks
  property p_test_bypass;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (st.sel_s2 == `MCG_SEL_TEST) |=>
      (processor_clock_out_o == $past(st.xtal_s2)
      && bus_clock_out_o == $past(st.xtal_s2));
  endproperty
  a_test_bypass: assert property (p_test_bypass) // R5
    else $error("test mode output differs from test clock");

  property p_ref_copy;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    1'b1 |=> reference_copy_out_o == $past(st.xtal_s2);
  endproperty
  a_ref_copy: assert property (p_ref_copy) // R3
    else $error("reference copy mismatch");

  property p_unlock_on_change;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (st.sel_s2 != st.sel_prev) |=> !clocks_locked_o;
  endproperty
  a_unlock_on_change: assert property (p_unlock_on_change) // R13
    else $error("lock held across select change");

  property p_settle_bound;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    st.settle_cnt <= LOCK_LAST;
  endproperty
  a_settle_bound: assert property (p_settle_bound) // R12
    else $error("settle counter beyond limit");

  property p_lock_rises;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    $rose(clocks_locked_o) |-> $past(st.settle_cnt) == LOCK_LAST;
  endproperty
  a_lock_rises: assert property (p_lock_rises) // R9
    else $error("lock asserted before settle interval");

  property p_float;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    fanout_enable_n_i |-> (bank_one_oe_o == 4'h0 && bank_two_oe_o == 4'h0);
  endproperty
  a_float: assert property (p_float) // R7
    else $error("fanout driven while disabled");

  property p_drive;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    !fanout_enable_n_i |-> (bank_one_oe_o == 4'hf
      && bank_two_oe_o == 4'hf
      && bank_one_outputs_o == {4{bank_one_input_i}}
      && bank_two_outputs_o == {4{bank_two_input_i}});
  endproperty
  a_drive: assert property (p_drive) // R8
    else $error("fanout output does not follow input");

  property p_banks;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    ($changed(bank_one_input_i) && $stable(bank_two_input_i)) |->
      ($stable(bank_two_outputs_o) && !$stable(bank_one_outputs_o));
  endproperty
  a_banks: assert property (p_banks) // R6
    else $error("banks not independent");

  property p_cpu_toggles;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (st.sel_s2 == `MCG_SEL_60)[*8] |-> !$stable(st.acc_cpu[AW-1:AW-4]);
  endproperty
  a_cpu_toggles: assert property (p_cpu_toggles) // R1
    else $error("processor accumulator stuck");

  property p_bus_run;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (st.sel_s2 != `MCG_SEL_TEST) |=>
      st.acc_bus == $past(st.acc_bus) + `MCG_INC_33;
  endproperty
  a_bus_run: assert property (p_bus_run) // R2
    else $error("bus clock accumulator not stepping");
endmodule // mcg_top

//--- mcg_xtal_model.sv
`timescale 1ns/100ps
module mcg_xtal_model (
  // bypass request from the bench
  input  wire logic test_en_i,
  // crystal pin
  output logic      crystal_o
);
  // steady reference, slower test clock in bypass; the 3.3 ns offset
  // keeps every edge clear of the core clock edges
  initial begin
    crystal_o = 1'b0;
    #3.3;
    forever #(test_en_i ? 60.0 : 35.0) crystal_o = ~crystal_o;
  end
endmodule // mcg_xtal_model

//--- motherboard_clock_gen_buffers_test.sv
`timescale 1ns/100ps
module motherboard_clock_gen_buffers_test;
  import mcg_pkg::*;
  localparam int unsigned SETTLE = 16;
  logic       core_clk_i, arst_n_i, sel_lo, sel_hi, en_n, b1, b2, tst;
  logic       xtal, pclk, bclk, rclk, locked, bp, pp;
  mcg_mode_t  mode;
  logic [3:0] y1, y2, oe1, oe2;
  logic [7:0] lfsr = 8'h5e;
  logic [1:0] codes [6] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h3, 2'h1};
  logic       hist [$];
  int         mismatches = 0, compares = 0, n, tg, tp;

  mcg_top #(.SETTLE_CYC(SETTLE)) u_dut (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .freq_select_lo_i(sel_lo), .freq_select_hi_i(sel_hi),
    .fanout_enable_n_i(en_n), .crystal_input_i(xtal),
    .processor_clock_out_o(pclk), .bus_clock_out_o(bclk),
    .reference_copy_out_o(rclk), .clocks_locked_o(locked),
    .mode_o(mode), .bank_one_input_i(b1), .bank_two_input_i(b2),
    .bank_one_outputs_o(y1), .bank_two_outputs_o(y2),
    .bank_one_oe_o(oe1), .bank_two_oe_o(oe2));
  mcg_xtal_model u_xtal (.test_en_i(tst), .crystal_o(xtal));

  // core clock
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  // crystal level seen at each core edge, newest first
  always @(posedge core_clk_i) begin
    hist.push_front(xtal);
    if (hist.size() > 4) void'(hist.pop_back());
  end

  function automatic logic [7:0] step(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(string nm, logic [3:0] exp, logic [3:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic conclude();
    if (mismatches == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // inputs always move 2 ns after the edge
  task automatic tick();
    @(posedge core_clk_i);
    #2;
  endtask

  // apply a select code and time the relock; bounded wait
  task automatic settle(logic [1:0] code);
    {sel_hi, sel_lo} = code;
    tg = 0;
    for (n = 1; n <= SETTLE + 20; n++) begin
      tick();
      if (n <= 4 && locked === 1'b0) tg = 1;
      if (tg == 1 && locked === 1'b1) break;
    end
    chk("lock_drop", 4'h1, tg[3:0]);
    chk("lock_time", 4'h1, n >= SETTLE - 3 && n <= SETTLE);
    if (n > SETTLE + 20) conclude();
  endtask

  // main sequence
  initial begin
    arst_n_i = 1'b0;
    {sel_lo, sel_hi, en_n, b1, b2, tst} = 6'h08;
    repeat (2) @(posedge core_clk_i);
    #2 arst_n_i = 1'b1;
    settle(2'h0);
    // random enable and bank levels, all combinations hit
    repeat (64) begin
      lfsr = step(lfsr);
      {en_n, b2, b1} = lfsr[2:0];
      #1;
      chk("oe1", {4{~en_n}}, oe1);
      chk("oe2", {4{~en_n}}, oe2);
      if (!en_n) begin
        chk("y1", {4{b1}}, y1);
        chk("y2", {4{b2}}, y2);
      end
      tick();
    end
    // every select code, test mode entered twice
    foreach (codes[i]) begin
      tst = (codes[i] == 2'h3);
      settle(codes[i]);
      chk("mode", codes[i], mode);
      tg = 0;
      tp = 0;
      bp = bclk;
      pp = pclk;
      repeat (40) begin
        tick();
        chk("ref", hist[2], rclk);
        if (tst) begin
          chk("cpu_t", hist[2], pclk);
          chk("bus_t", hist[2], bclk);
        end
        tg += (bclk !== bp);
        tp += (pclk !== pp);
        bp = bclk;
        pp = pclk;
      end
      if (!tst) begin
        chk("bus_run", 4'h1, tg > 4);
        chk("cpu_run", 4'h1, tp > 4);
      end
    end
    // reset in mid-run drops lock and mode at once
    arst_n_i = 1'b0;
    #1;
    chk("rst_lock", 4'h0, locked);
    chk("rst_mode", MCG_M50, mode);
    tick();
    arst_n_i = 1'b1;
    settle(2'h1);
    chk("mode_rst", MCG_M60, mode);
    conclude();
  end
endmodule // motherboard_clock_gen_buffers_test
